// [usf_pkg.sv]
// Package for the serial status flag block: register map, field layout, constants
`default_nettype none
package usf_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] STAT_CTRL_OFFS = 8'h00;
    localparam logic [7:0] MODE_OFFS = 8'h04;
    localparam logic [7:0] RXDATA_OFFS = 8'h08;
    localparam logic [7:0] TXDATA_OFFS = 8'h0C;
    // ****************************************************************
    // Field positions in the status and control word
    // ****************************************************************
    localparam int TX_DONE_BIT = 8;
    localparam int RXSEL_LSB = 6;
    localparam int ADDR_EN_BIT = 5;
    localparam int RX_IDLE_BIT = 4;
    localparam int PARITY_ERR_FLAG_BIT = 3;
    localparam int FRAMING_ERR_FLAG_BIT = 2;
    localparam int OVR_BIT = 1;
    localparam int AVAIL_BIT = 0;
    localparam logic [31:0] STAT_CTRL_RESET = 32'h0000_0110;
    // ****************************************************************
    // Sizes and thresholds
    // ****************************************************************
    localparam int RX_DEPTH = 8;
    localparam int RX_CNT_W = 4;
    localparam logic [3:0] RX_LVL_HALF = 4'h4;
    localparam logic [3:0] RX_LVL_3Q = 4'h6;
    localparam int TX_DEPTH = 4;
    localparam int CHAR_W = 9;
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0015;

    typedef enum logic [1:0] {
        RXSEL_ANY = 2'b00,
        RXSEL_HALF = 2'b01,
        RXSEL_3Q = 2'b10,
        RXSEL_RSVD = 2'b11
    } usf_rxsel_type;

    typedef enum logic [1:0] {
        FMT_8N = 2'b00,
        FMT_8E = 2'b01,
        FMT_8O = 2'b10,
        FMT_9N = 2'b11
    } usf_fmt_type;

    typedef struct packed {
        logic [8:0] data;
        logic parity_err_flag;
        logic framing_err_flag;
    } usf_rxchar_type;
endpackage
`default_nettype wire

// [usf_fifo.sv]
// Parameterised valid/ready FIFO used in the transmit data path
`timescale 1ns/1ps
`default_nettype none
module usf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn || flush) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // usf_fifo
`default_nettype wire

// [usf_top.sv]
// Serial port with status/control flags, receive buffer and APB registers
// ****************************************************************
// Overview of operation
// - Transmit-done reads 1 only when shifter and transmit buffer are both empty.
// - Receive flag threshold: 00 one char, 01 four, 10 six, 11 reserved.
// - With address detect on, a 9-bit char with bit 8 set is an address.
// - Address detect enable has no effect outside the 9-bit format.
// - Receiver idle flag is 1 when idle, 0 during a character.
// - Parity error flag shows the parity status of the current character.
// - Framing error flag shows a bad stop bit on the current character.
// - Overrun flag is set by hardware only; only a software zero clears it.
// - Overrun sets when a character arrives with the receive buffer full.
// - Clearing a set overrun flag empties the receive buffer and shifter.
// - Data-available reads 1 while the receive buffer holds any character.
// - Format code 11 selects nine data bits without parity.
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module usf_top (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic rx_irq,
    output logic addr_char_seen
);
    import usf_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [1:0] rx_irq_threshold_sel_ff;
    logic addr_char_detect_en_ff;
    logic rx_overrun_flag_ff;
    usf_fmt_type parity_data_format_ff;
    logic [15:0] baud_div_ff;
    logic [2:0] rx_sync_ff;
    logic rx_in_ff;
    usf_rxchar_type rx_mem_ff [RX_DEPTH];
    logic [2:0] rx_wr_ff;
    logic [2:0] rx_rd_ff;
    logic [RX_CNT_W-1:0] rx_cnt_ff;
    logic [15:0] tick_cnt_ff;
    logic tick;
    logic [3:0] rx_ph_ff;
    logic [3:0] rx_bit_ff;
    logic [10:0] rx_shift_reg;
    logic rx_busy_ff;
    logic rx_done;
    logic [3:0] tx_ph_ff;
    logic [3:0] tx_bit_ff;
    logic [11:0] tx_sh_ff;
    logic tx_busy_ff;
    logic [31:0] prdata_ff;
    logic wr_en;
    logic rd_en;
    logic ovr_clear;
    logic tx_push;
    logic tx_push_ready;
    logic tx_q_valid;
    logic [CHAR_W-1:0] tx_q_data;
    logic tx_load;
    logic nine_bit;
    logic has_par;
    logic [3:0] frame_bits;
    logic rx_pop;
    logic rx_full;
    logic exp_par;
    usf_rxchar_type rx_head;
    usf_rxchar_type rx_new;
    logic [31:0] stat_word;

    assign nine_bit = (parity_data_format_ff == FMT_9N);
    assign has_par = (parity_data_format_ff == FMT_8E) || (parity_data_format_ff == FMT_8O);
    // Data bits plus optional parity plus stop
    assign frame_bits = (nine_bit || has_par) ? 4'hA : 4'h9;

    // ****************************************************************
    // APB slave, zero wait states
    // ****************************************************************
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign prdata = prdata_ff;
    assign ovr_clear = wr_en && (paddr == STAT_CTRL_OFFS) && !pwdata[OVR_BIT] && rx_overrun_flag_ff;
    // Full queue drops the write silently
    assign tx_push = wr_en && (paddr == TXDATA_OFFS) && tx_push_ready;
    assign rx_pop = rd_en && (paddr == RXDATA_OFFS) && (rx_cnt_ff != '0);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_irq_threshold_sel_ff <= RXSEL_ANY;
            addr_char_detect_en_ff <= 1'b0;
            parity_data_format_ff <= FMT_8N;
            baud_div_ff <= BAUD_DIV_RESET;
        end else if (wr_en && paddr == STAT_CTRL_OFFS) begin
            rx_irq_threshold_sel_ff <= pwdata[RXSEL_LSB +: 2];
            addr_char_detect_en_ff <= pwdata[ADDR_EN_BIT];
        end else if (wr_en && paddr == MODE_OFFS) begin
            parity_data_format_ff <= usf_fmt_type'(pwdata[1:0]);
            baud_div_ff <= pwdata[31:16];
        end
    end

    always_comb begin
        stat_word = '0;
        stat_word[TX_DONE_BIT] = !tx_busy_ff && !tx_q_valid;
        stat_word[RXSEL_LSB +: 2] = rx_irq_threshold_sel_ff;
        stat_word[ADDR_EN_BIT] = addr_char_detect_en_ff;
        stat_word[RX_IDLE_BIT] = !rx_busy_ff;
        stat_word[PARITY_ERR_FLAG_BIT] = (rx_cnt_ff != '0) && rx_head.parity_err_flag;
        stat_word[FRAMING_ERR_FLAG_BIT] = (rx_cnt_ff != '0) && rx_head.framing_err_flag;
        stat_word[OVR_BIT] = rx_overrun_flag_ff;
        stat_word[AVAIL_BIT] = (rx_cnt_ff != '0);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prdata_ff <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                STAT_CTRL_OFFS: prdata_ff <= stat_word;
                MODE_OFFS: prdata_ff <= {baud_div_ff, 14'h0000, parity_data_format_ff};
                RXDATA_OFFS: prdata_ff <= {23'h00_0000, rx_head.data};
                default: prdata_ff <= '0;
            endcase
        end
    end

    // ****************************************************************
    // Baud tick, 16 ticks per bit
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn || tick_cnt_ff >= baud_div_ff) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
        end
    end
    assign tick = resetn && (tick_cnt_ff >= baud_div_ff);

    // ****************************************************************
    // Receiver
    // ****************************************************************
    // Three stages; a level counts once the last two agree
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_sync_ff <= 3'b111;
            rx_in_ff <= 1'b1;
        end else begin
            rx_sync_ff <= {rx_sync_ff[1:0], rx_pin};
            if (rx_sync_ff[1] == rx_sync_ff[2]) begin
                rx_in_ff <= rx_sync_ff[2];
            end
        end
    end

    // Shifter drops its frame on an overrun clear
    always_ff @(posedge core_clk) begin
        if (!resetn || ovr_clear) begin
            rx_busy_ff <= 1'b0;
            rx_ph_ff <= '0;
            rx_bit_ff <= '0;
            rx_shift_reg <= '0;
        end else if (tick) begin
            if (!rx_busy_ff) begin
                if (!rx_in_ff) begin
                    rx_busy_ff <= 1'b1;
                    rx_ph_ff <= 4'h0;
                    rx_bit_ff <= 4'h0;
                end
            end else begin
                rx_ph_ff <= rx_ph_ff + 4'h1;
                if (rx_ph_ff == 4'h7) begin
                    if (rx_bit_ff == 4'h0 && rx_in_ff) begin
                        rx_busy_ff <= 1'b0; // False start
                    end else begin
                        if (rx_bit_ff != 4'h0) begin
                            rx_shift_reg <= {rx_in_ff, rx_shift_reg[10:1]};
                        end
                        if (rx_bit_ff == frame_bits) begin
                            rx_busy_ff <= 1'b0;
                        end
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                    end
                end
            end
        end
    end
    assign rx_done = tick && rx_busy_ff && (rx_ph_ff == 4'h7) && (rx_bit_ff == frame_bits) && !ovr_clear;

    // Realign the captured bits: last data or parity bit at the top, data below; stop taken from rx_in_ff
    always_comb begin
        rx_new = '0;
        rx_new.framing_err_flag = !rx_in_ff;
        exp_par = 1'b0;
        if (nine_bit) begin
            rx_new.data = rx_shift_reg[10:2];
        end else if (has_par) begin
            rx_new.data = {1'b0, rx_shift_reg[9:2]};
            exp_par = ^rx_shift_reg[9:2] ^ (parity_data_format_ff == FMT_8O);
            rx_new.parity_err_flag = (rx_shift_reg[10] != exp_par);
        end else begin
            rx_new.data = {1'b0, rx_shift_reg[10:3]};
        end
    end

    // ****************************************************************
    // Receive buffer, eight entries
    // ****************************************************************
    assign rx_full = (rx_cnt_ff == 4'(RX_DEPTH));
    assign rx_head = rx_mem_ff[rx_rd_ff];

    always_ff @(posedge core_clk) begin
        if (rx_done && !rx_full) begin
            rx_mem_ff[rx_wr_ff] <= rx_new;
        end
    end

    // Full buffer keeps old data; new character is dropped
    always_ff @(posedge core_clk) begin
        if (!resetn || ovr_clear) begin
            rx_wr_ff <= '0;
            rx_rd_ff <= '0;
            rx_cnt_ff <= '0;
        end else begin
            if (rx_done && !rx_full) begin
                rx_wr_ff <= rx_wr_ff + 3'h1;
            end
            if (rx_pop) begin
                rx_rd_ff <= rx_rd_ff + 3'h1;
            end
            rx_cnt_ff <= rx_cnt_ff + RX_CNT_W'(rx_done && !rx_full) - RX_CNT_W'(rx_pop);
        end
    end

    // Set only by hardware; the write of zero is the sole clear
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_overrun_flag_ff <= 1'b0;
        end else if (rx_done && rx_full) begin
            rx_overrun_flag_ff <= 1'b1;
        end else if (ovr_clear) begin
            rx_overrun_flag_ff <= 1'b0;
        end
    end

    always_comb begin
        unique case (usf_rxsel_type'(rx_irq_threshold_sel_ff))
            RXSEL_ANY: rx_irq = (rx_cnt_ff != '0);
            RXSEL_HALF: rx_irq = (rx_cnt_ff >= RX_LVL_HALF);
            RXSEL_3Q: rx_irq = (rx_cnt_ff >= RX_LVL_3Q);
            RXSEL_RSVD: rx_irq = 1'b0;
        endcase
    end

    // Address flag only meaningful in the 9-bit format
    assign addr_char_seen = (rx_cnt_ff != '0) && addr_char_detect_en_ff && nine_bit
        && rx_head.data[8];

    // ****************************************************************
    // Transmitter
    // ****************************************************************
    usf_fifo #(
        .WIDTH(CHAR_W),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .flush(1'b0),
        .in_valid(tx_push),
        .in_ready(tx_push_ready),
        .in_data(pwdata[CHAR_W-1:0]),
        .out_valid(tx_q_valid),
        .out_ready(tx_load),
        .out_data(tx_q_data)
    );
    assign tx_load = tick && !tx_busy_ff;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tx_busy_ff <= 1'b0;
            tx_sh_ff <= 12'hFFF;
            tx_ph_ff <= '0;
            tx_bit_ff <= '0;
        end else if (tx_load && tx_q_valid) begin
            tx_busy_ff <= 1'b1;
            tx_ph_ff <= '0;
            tx_bit_ff <= '0;
            if (nine_bit) begin
                tx_sh_ff <= {2'b11, tx_q_data, 1'b0};
            end else if (has_par) begin
                tx_sh_ff <= {2'b11, ^tx_q_data[7:0] ^ (parity_data_format_ff == FMT_8O), tx_q_data[7:0], 1'b0};
            end else begin
                tx_sh_ff <= {3'b111, tx_q_data[7:0], 1'b0};
            end
        end else if (tick && tx_busy_ff) begin
            tx_ph_ff <= tx_ph_ff + 4'h1;
            if (tx_ph_ff == 4'hF) begin
                tx_sh_ff <= {1'b1, tx_sh_ff[11:1]};
                tx_bit_ff <= tx_bit_ff + 4'h1;
                if (tx_bit_ff == frame_bits) begin
                    tx_busy_ff <= 1'b0;
                end
            end
        end
    end
    assign tx_pin = tx_sh_ff[0];

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_tx_done_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        (tx_busy_ff || tx_q_valid) |-> !stat_word[TX_DONE_BIT]) else $error("tx done set while busy");
    a_irq_half_level: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_irq_threshold_sel_ff == 2'b01) |-> (rx_irq == (rx_cnt_ff >= 4'h4))) else $error("half level");
    a_irq_3q_level: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_irq_threshold_sel_ff == 2'b10 && rx_cnt_ff == 4'h5) |-> !rx_irq) else $error("3q level");
    a_addr_fmt_gate: assert property (@(posedge core_clk) disable iff (!resetn)
        !nine_bit |-> !addr_char_seen) else $error("address flag outside 9-bit");
    a_ovr_sets_full: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_done && rx_full) |=> rx_overrun_flag_ff) else $error("overrun not set");
    a_ovr_sticky_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_overrun_flag_ff && !ovr_clear) |=> rx_overrun_flag_ff) else $error("overrun lost");
    a_ovr_clear_flush: assert property (@(posedge core_clk) disable iff (!resetn)
        ovr_clear |=> (rx_cnt_ff == '0 && !rx_busy_ff)) else $error("flush failed");
    a_avail_tracks: assert property (@(posedge core_clk) disable iff (!resetn)
        (rx_done && !rx_full && !rx_pop) |=> stat_word[AVAIL_BIT]) else $error("avail not set");
    a_buf_depth: assert property (@(posedge core_clk) disable iff (!resetn)
        rx_cnt_ff <= 4'h8) else $error("buffer overfilled");
endmodule // usf_top
`default_nettype wire

// [usf_peer_model.sv]
// Remote serial peer: drives the receive line and decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module usf_peer_model #(
    parameter int BIT_CLKS = 16
) (
    input wire logic core_clk,
    output logic rx_line,
    input wire logic tx_line
);
    logic [7:0] got_q[$];
    logic [7:0] sh;

    // Line idles high between frames, as a real transmitter would leave it
    initial rx_line = 1'b1;

    task automatic put_bit(input logic b);
        rx_line <= b;
        repeat (BIT_CLKS) @(posedge core_clk);
    endtask

    // One frame: start, data LSB first, optional ninth bit or even parity, stop, one idle bit
    task automatic send(input logic [8:0] d, input logic nine, input logic par_on, input logic bad_par,
                        input logic bad_stop);
        logic p;
        p = (^d[7:0]) ^ bad_par;
        @(posedge core_clk);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(d[i]);
        if (nine) put_bit(d[8]);
        if (par_on) put_bit(p);
        put_bit(~bad_stop);
        put_bit(1'b1);
    endtask

    // Samples mid-bit; only 8N frames are decoded, enough for the transmit tests
    initial begin
        forever begin
            @(negedge tx_line);
            repeat (BIT_CLKS / 2) @(posedge core_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge core_clk);
                sh[i] = tx_line;
            end
            got_q.push_back(sh);
            repeat (BIT_CLKS) @(posedge core_clk);
        end
    end
endmodule // usf_peer_model
`default_nettype wire

// [usf_tb.sv]
// Self-checking testbench for the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import usf_pkg::*;
    localparam int BITC = 16;
    localparam int CEIL = 40000;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic rx_pin, tx_pin, rx_irq, addr_char_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [3:0] thr[3];
    int mismatches, check_count, cyc, n;

    usf_top u_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_irq(rx_irq), .addr_char_seen(addr_char_seen));
    usf_peer_model #(.BIT_CLKS(BITC)) u_peer (.core_clk(core_clk), .rx_line(rx_pin), .tx_line(tx_pin));

    // ****************************************************************
    // Clock, timeout, shared tasks
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == CEIL) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; releases one idle cycle so transfers never collide
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Overrun bit written as 1 unless a clear is meant
    task automatic stat(input logic [1:0] sel, input logic aden, input logic ovr);
        apb(1'b1, STAT_CTRL_OFFS, {24'h00_0000, sel, aden, 3'b000, ovr, 1'b0});
    endtask

    task automatic snd(input logic [8:0] d, input logic nine, input logic par, input logic badp, input logic bads);
        u_peer.send(d, nine, par, badp, bads);
        repeat (4) @(posedge core_clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rd(STAT_CTRL_OFFS);
        check(v, STAT_CTRL_RESET);
        rd(MODE_OFFS);
        check(v, 32'h0015_0000);
        rd(8'h10);
        check(v, 32'h0000_0000);
        check(pslverr, 1'b0);
        apb(1'b1, MODE_OFFS, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_idle_avail;
        fork
            u_peer.send(9'h05A, 1'b0, 1'b0, 1'b0, 1'b0);
            begin
                repeat (BITC * 4) @(posedge core_clk);
                rd(STAT_CTRL_OFFS);
                check(v[RX_IDLE_BIT], 1'b0);
                check(v[AVAIL_BIT], 1'b0);
            end
        join
        repeat (4) @(posedge core_clk);
        rd(STAT_CTRL_OFFS);
        check(v[RX_IDLE_BIT], 1'b1);
        check(v[AVAIL_BIT], 1'b1);
        rd(RXDATA_OFFS);
        check(v[8:0], 9'h05A);
        rd(STAT_CTRL_OFFS);
        check(v[AVAIL_BIT], 1'b0);
        $display("test idle_avail done");
    endtask

    // Buffer left full on exit, ready for the overrun case
    task automatic t_thresholds;
        thr[0] = 4'h1;
        thr[1] = RX_LVL_HALF;
        thr[2] = RX_LVL_3Q;
        for (int k = 1; k <= RX_DEPTH; k++) begin
            snd(9'h040 + 9'(k), 1'b0, 1'b0, 1'b0, 1'b0);
            for (int s = 0; s < 3; s++) begin
                stat(2'(s), 1'b0, 1'b1);
                check(rx_irq, 4'(k) >= thr[s]);
            end
        end
        $display("test thresholds done");
    endtask

    task automatic t_overrun;
        rd(STAT_CTRL_OFFS);
        check(v[OVR_BIT], 1'b0);
        snd(9'h0EE, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(STAT_CTRL_OFFS);
        check(v[1:0], 2'b11);
        stat(2'b10, 1'b0, 1'b1);
        rd(STAT_CTRL_OFFS);
        check(v[OVR_BIT], 1'b1);
        check(rx_irq, 1'b1);
        stat(2'b00, 1'b0, 1'b0);
        rd(STAT_CTRL_OFFS);
        check(v[1:0], 2'b00);
        check(rx_irq, 1'b0);
        $display("test overrun done");
    endtask

    task automatic t_errors;
        apb(1'b1, MODE_OFFS, 32'h0000_0001);
        snd(9'h0C3, 1'b0, 1'b1, 1'b1, 1'b0);
        rd(STAT_CTRL_OFFS);
        check(v[3:2], 2'b10);
        rd(RXDATA_OFFS);
        snd(9'h03C, 1'b0, 1'b1, 1'b0, 1'b1);
        rd(STAT_CTRL_OFFS);
        check(v[3:2], 2'b01);
        rd(RXDATA_OFFS);
        snd(9'h096, 1'b0, 1'b1, 1'b0, 1'b0);
        rd(STAT_CTRL_OFFS);
        check(v[3:2], 2'b00);
        rd(RXDATA_OFFS);
        check(v[8:0], 9'h096);
        // Odd parity: the peer's flipped even bit is the correct odd bit
        apb(1'b1, MODE_OFFS, 32'h0000_0002);
        snd(9'h0C3, 1'b0, 1'b1, 1'b1, 1'b0);
        rd(STAT_CTRL_OFFS);
        check(v[3:2], 2'b00);
        rd(RXDATA_OFFS);
        check(v[8:0], 9'h0C3);
        snd(9'h0C3, 1'b0, 1'b1, 1'b0, 1'b0);
        rd(STAT_CTRL_OFFS);
        check(v[3:2], 2'b10);
        rd(RXDATA_OFFS);
        $display("test errors done");
    endtask

    task automatic t_addr;
        apb(1'b1, MODE_OFFS, 32'h0000_0003);
        stat(2'b00, 1'b1, 1'b1);
        snd(9'h1A5, 1'b1, 1'b0, 1'b0, 1'b0);
        check(addr_char_seen, 1'b1);
        rd(RXDATA_OFFS);
        check(v[8:0], 9'h1A5);
        snd(9'h0A5, 1'b1, 1'b0, 1'b0, 1'b0);
        check(addr_char_seen, 1'b0);
        rd(RXDATA_OFFS);
        stat(2'b00, 1'b0, 1'b1);
        snd(9'h1A5, 1'b1, 1'b0, 1'b0, 1'b0);
        check(addr_char_seen, 1'b0);
        stat(2'b00, 1'b1, 1'b1);
        check(addr_char_seen, 1'b1);
        // Same stored address char, format switched away from 9-bit
        apb(1'b1, MODE_OFFS, 32'h0000_0000);
        check(addr_char_seen, 1'b0);
        rd(RXDATA_OFFS);
        stat(2'b00, 1'b1, 1'b1);
        snd(9'h0FF, 1'b0, 1'b0, 1'b0, 1'b0);
        check(addr_char_seen, 1'b0);
        rd(RXDATA_OFFS);
        check(v[8:0], 9'h0FF);
        $display("test addr done");
    endtask

    // Shifter plus four queued words accept five; the sixth write meets a full buffer
    task automatic t_tx;
        for (int i = 0; i < 6; i++) apb(1'b1, TXDATA_OFFS, 32'h0000_0030 + 32'(i));
        rd(STAT_CTRL_OFFS);
        check(v[TX_DONE_BIT], 1'b0);
        n = 0;
        while (u_peer.got_q.size() < 5 && n < 2000) begin
            n++;
            @(posedge core_clk);
        end
        rd(STAT_CTRL_OFFS);
        check(v[TX_DONE_BIT], 1'b0);
        repeat (BITC * 12) @(posedge core_clk);
        check(u_peer.got_q.size(), 5);
        for (int i = 0; i < 5; i++) check(u_peer.got_q[i], 8'h30 + 8'(i));
        rd(STAT_CTRL_OFFS);
        check(v[TX_DONE_BIT], 1'b1);
        $display("test tx done");
    endtask

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mismatches = 0;
        check_count = 0;
        cyc = 0;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_idle_avail();
        t_thresholds();
        t_overrun();
        t_errors();
        t_addr();
        t_tx();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
